// File: common/clih_byte_if.sv
// interface: assembled byte stream from the nibble packer to the interpreter
`default_nettype none
interface clih_byte_if;
   logic       valid;
   logic       register_select;
   logic [7:0] data;
   modport src (output valid, output register_select, output data);
   modport dst (input valid, input register_select, input data);
endinterface : clih_byte_if
`default_nettype wire

// File: common/clih_pkg.sv
// package: constants for the character display instruction handler
`default_nettype none
package clih_pkg;
   localparam int unsigned RAM_DEPTH   = 80;             // text ram size
   localparam int unsigned LINE_LEN    = 40;             // positions per line in two-line mode
   localparam logic [6:0]  LINE2_BASE  = 7'h40;          // address of second line head
   localparam logic [6:0]  LINE1_LAST  = 7'h27;          // last address of line one
   localparam logic [6:0]  LINE2_LAST  = 7'h67;
   localparam logic [6:0]  RAM_LAST    = 7'h4F;          // last address in one-line mode
   localparam logic [5:0]  SHIFT_LAST  = 6'h27;          // window offset wraps per line
   localparam logic [5:0]  GLYPH_LAST  = 6'h3F;
   localparam logic [7:0]  BLANK_CODE  = 8'h20;          // blank character after init
   localparam logic [6:0]  HOME_ADDR   = 7'h00;
   // instruction class bit positions (highest set bit decides)
   localparam int unsigned B_DDADDR = 7;
   localparam int unsigned B_CGADDR = 6;
   localparam int unsigned B_FUNC   = 5;
   localparam int unsigned B_SHIFT  = 4;
   localparam int unsigned B_DISP   = 3;
   localparam int unsigned B_ENTRY  = 2;
   localparam int unsigned B_HOME   = 1;
   localparam int unsigned B_CLEAR  = 0;
   // field positions
   localparam int unsigned F_DL = 4;  // width: 1 = eight-bit
   localparam int unsigned F_N  = 3;  // lines: 1 = two lines
   localparam int unsigned F_VG = 0;  // drive: 1 = internal generator
   localparam int unsigned F_SC = 3;  // 1 = shift display, 0 = move cursor
   localparam int unsigned F_RL = 2;  // right when set
   localparam int unsigned F_D  = 2;
   localparam int unsigned F_C  = 1;
   localparam int unsigned F_B  = 0;
   localparam int unsigned F_ID = 1;
   localparam int unsigned F_S  = 0;
endpackage : clih_pkg
`default_nettype wire

// File: rtl/clih_handler.sv
// module: instruction and data interpreter with text ram and display window
`default_nettype none
module clih_handler
   import clih_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,             // synchronous power-on reset
   input  wire logic       strobe_i,            // one-cycle write strobe
   input  wire logic       register_select_i,   // 0 instruction, 1 data
   input  wire logic [7:0] parallel_data_lines_i,
   input  wire logic [6:0] rd_addr_i,           // display-side text ram read
   output logic [7:0]      rd_data_o,
   output logic [6:0]      address_counter_o,
   output logic            glyph_sel_o,         // address counter points at glyph ram
   output logic [5:0]      window_shift_o,      // visible window offset
   output logic            eight_bit_o,
   output logic            two_line_o,
   output logic            internal_drive_o,    // panel_drive_voltage from internal generator
   output logic            display_on_o,
   output logic            cursor_on_o,
   output logic            blink_on_o,
   output logic            increment_o,
   output logic            shift_on_write_o,
   output logic            byte_done_o          // pulse per accepted byte
);
   clih_byte_if bi ();

   // the packer holds its pairing state in reset too, so no strobe leaks through
   clih_packer i_clih_packer (
      .sys_clk_i             (sys_clk_i),
      .rst_n_i               (rst_n_i),
      .strobe_i              (strobe_i),
      .register_select_i     (register_select_i),
      .parallel_data_lines_i (parallel_data_lines_i),
      .eight_bit_i           (eight_bit_o),
      .out                   (bi)
   );

   logic [7:0] ram_r [RAM_DEPTH];
   logic [7:0] glyph_r [int'(GLYPH_LAST) + 1];
   logic [6:0] address_counter_r;
   logic       cg_r;
   logic [5:0] shift_r;
   logic [6:0] address_counter_nxt;
   logic [5:0] shift_nxt;
   logic       is_data;
   logic       is_instr;
   logic [7:0] d;

   assign is_data  = bi.valid && bi.register_select;
   assign is_instr = bi.valid && !bi.register_select;
   assign d        = bi.data;

   // step address by one, wrapping line by line in two-line mode
   function automatic logic [6:0] clih_step(input logic [6:0] a, input logic up, input logic two,
                                            input logic cg);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (cg)
         r = {1'b0, r[5:0]};
      else if (two) begin
         if (up && a == LINE1_LAST)      r = LINE2_BASE;
         else if (up && a == LINE2_LAST) r = HOME_ADDR;
         else if (!up && a == HOME_ADDR) r = LINE2_LAST;
         else if (!up && a == LINE2_BASE) r = LINE1_LAST;
      end else begin
         if (up && a == RAM_LAST)        r = HOME_ADDR;
         else if (!up && a == HOME_ADDR) r = RAM_LAST;
      end
      return r;
   endfunction

   // window offset moves both lines alike; lines never borrow from each other
   function automatic logic [5:0] clih_win(input logic [5:0] s, input logic left);
      logic [5:0] r;
      if (left) r = (s == SHIFT_LAST) ? 6'h00 : s + 6'h01;
      else      r = (s == 6'h00) ? SHIFT_LAST : s - 6'h01;
      return r;
   endfunction

   // next address counter and window
   always_comb begin
      address_counter_nxt = address_counter_r;
      shift_nxt           = shift_r;
      if (is_data) begin
         address_counter_nxt = clih_step(address_counter_r, increment_o, two_line_o, cg_r);
         if (shift_on_write_o && !cg_r)
            shift_nxt = clih_win(shift_r, increment_o);
      end else if (is_instr) begin
         if (d[B_DDADDR])
            address_counter_nxt = d[6:0];
         else if (d[B_CGADDR])
            address_counter_nxt = {1'b0, d[5:0]};
         else if (d[B_FUNC])
            address_counter_nxt = address_counter_r;
         else if (d[B_SHIFT]) begin
            // a display shift moves the window only; the counter keeps its character, so entry resumes in place
            if (d[F_SC])
               shift_nxt = clih_win(shift_r, !d[F_RL]);
            else
               address_counter_nxt = clih_step(address_counter_r, d[F_RL], two_line_o, cg_r);
         end else if (d[B_DISP] || d[B_ENTRY])
            address_counter_nxt = address_counter_r;
         else if (d[B_HOME] || d[B_CLEAR]) begin
            address_counter_nxt = HOME_ADDR;
            shift_nxt           = 6'h00;
         end
      end
   end

   // address counter, ram select and window
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         address_counter_r <= HOME_ADDR;
         cg_r              <= 1'b0;
         shift_r           <= 6'h00;
      end else begin
         address_counter_r <= address_counter_nxt;
         shift_r <= shift_nxt;
         if (is_instr && d[B_DDADDR])      cg_r <= 1'b0;
         else if (is_instr && d[B_CGADDR]) cg_r <= 1'b1;
         else if (is_instr && !d[B_FUNC] && !d[B_SHIFT] && !d[B_DISP] && !d[B_ENTRY]
                  && (d[B_HOME] || d[B_CLEAR])) cg_r <= 1'b0;
      end
   end

   // text ram: only data writes and clear touch contents, shifts never do
   genvar gi;
   generate
      for (gi = 0; gi < RAM_DEPTH; gi++) begin : g_ram
         localparam logic [6:0] IDX = 7'(gi < LINE_LEN ? gi : gi - LINE_LEN + LINE2_BASE);
         always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i)
               ram_r[gi] <= BLANK_CODE;
            else if (is_data && !cg_r && address_counter_r == (two_line_o ? IDX : 7'(gi)))
               ram_r[gi] <= d;
            else if (is_instr && d == 8'h01)
               ram_r[gi] <= BLANK_CODE;
         end
      end
      for (gi = 0; gi <= int'(GLYPH_LAST); gi++) begin : g_glyph
         always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i)
               glyph_r[gi] <= 8'h00;
            else if (is_data && cg_r && address_counter_r[5:0] == 6'(gi))
               glyph_r[gi] <= d;
         end
      end
   endgenerate

   // configuration held by function set, on/off and entry mode
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         eight_bit_o      <= 1'b1;
         two_line_o       <= 1'b0;
         internal_drive_o <= 1'b0;
         display_on_o     <= 1'b0;
         cursor_on_o      <= 1'b0;
         blink_on_o       <= 1'b0;
         increment_o      <= 1'b1;
         shift_on_write_o <= 1'b0;
      end else if (is_instr && !d[B_DDADDR] && !d[B_CGADDR]) begin
         if (d[B_FUNC]) begin
            eight_bit_o      <= d[F_DL];
            two_line_o       <= d[F_N];
            internal_drive_o <= d[F_VG];
         end else if (!d[B_SHIFT] && d[B_DISP]) begin
            display_on_o <= d[F_D];
            cursor_on_o  <= d[F_C];
            blink_on_o   <= d[F_B];
         end else if (!d[B_SHIFT] && d[B_ENTRY]) begin
            increment_o      <= d[F_ID];
            shift_on_write_o <= d[F_S];
         end
      end
   end

   // display-side read, registered; addresses past the ram read blank
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i)
         rd_data_o <= BLANK_CODE;
      else if (rd_addr_i < 7'(LINE_LEN))
         rd_data_o <= ram_r[rd_addr_i];
      else if (two_line_o && rd_addr_i >= LINE2_BASE && rd_addr_i <= LINE2_LAST)
         rd_data_o <= ram_r[7'(rd_addr_i - LINE2_BASE + 7'(LINE_LEN))];
      else if (!two_line_o && rd_addr_i <= RAM_LAST)
         rd_data_o <= ram_r[rd_addr_i];
      else
         rd_data_o <= BLANK_CODE;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) byte_done_o <= 1'b0;
      else          byte_done_o <= bi.valid;
   end

   assign address_counter_o = address_counter_r;
   assign glyph_sel_o       = cg_r;
   assign window_shift_o    = shift_r;
endmodule : clih_handler
`default_nettype wire

// File: rtl/clih_packer.sv
// module: packs parallel strobes into bytes, handling the four-bit width
`default_nettype none
module clih_packer
   import clih_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       strobe_i,
   input  wire logic       register_select_i,
   input  wire logic [7:0] parallel_data_lines_i,
   input  wire logic       eight_bit_i,
   clih_byte_if.src        out
);
   logic       half_r;   // upper nibble held, waiting for lower
   logic [3:0] upper_r;

   // nibble pairing; in eight-bit width every strobe is a whole byte
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         half_r  <= 1'b0;
         upper_r <= 4'h0;
      end else if (strobe_i) begin
         if (eight_bit_i)
            half_r <= 1'b0;
         else if (!half_r) begin
            half_r  <= 1'b1;
            upper_r <= parallel_data_lines_i[7:4];
         end else
            half_r <= 1'b0;
      end
   end

   // byte out, registered
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         out.valid           <= 1'b0;
         out.register_select <= 1'b0;
         out.data            <= 8'h00;
      end else begin
         out.valid <= strobe_i && (eight_bit_i || half_r);
         if (strobe_i) begin
            out.register_select <= register_select_i;
            out.data <= eight_bit_i ? parallel_data_lines_i
                                    : {upper_r, parallel_data_lines_i[7:4]};
         end
      end
   end
endmodule : clih_packer
`default_nettype wire

// File: tb/clih_handler_assertions.sv
// checker: port-level cause and count relations of the instruction handler
`default_nettype none
module clih_handler_assertions
   import clih_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       rst_n_i,
   input wire logic       strobe_i,
   input wire logic       register_select_i,
   input wire logic [7:0] parallel_data_lines_i,
   input wire logic [6:0] rd_addr_i,
   input wire logic [7:0] rd_data_o,
   input wire logic [6:0] address_counter_o,
   input wire logic       glyph_sel_o,
   input wire logic [5:0] window_shift_o,
   input wire logic       eight_bit_o,
   input wire logic       two_line_o,
   input wire logic       internal_drive_o,
   input wire logic       display_on_o,
   input wire logic       cursor_on_o,
   input wire logic       blink_on_o,
   input wire logic       increment_o,
   input wire logic       shift_on_write_o,
   input wire logic       byte_done_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // whole-byte data write; nibble pairs are left out since their timing differs
   logic wr8;
   assign wr8 = strobe_i && register_select_i && eight_bit_o;
   // reset defaults, then causes and exact steps, each tied to the strobe two edges back
   AST_RESET_DEFAULTS: assert property ($rose(rst_n_i) |-> eight_bit_o && increment_o && !display_on_o
      && address_counter_o == HOME_ADDR && window_shift_o == 6'h00) else $error("reset defaults wrong");
   AST_DONE_CAUSE: assert property (byte_done_o |-> $past(strobe_i, 2) && $past(rst_n_i, 2))
      else $error("done without accepted strobe");
   AST_AC_CAUSE: assert property ($changed(address_counter_o) |-> $past(strobe_i, 2))
      else $error("counter moved with no strobe");
   AST_CFG_CAUSE: assert property ($changed({eight_bit_o, two_line_o, internal_drive_o, display_on_o, cursor_on_o})
      |-> $past(strobe_i, 2) && !$past(register_select_i, 2)) else $error("config moved with no instruction");
   AST_INC_ONE: assert property (wr8 && increment_o && !two_line_o && !glyph_sel_o && address_counter_o < RAM_LAST
      |-> ##2 address_counter_o == $past(address_counter_o) + 7'h01) else $error("counter step wrong");
   AST_NO_SHIFT: assert property (wr8 && !shift_on_write_o |-> ##2 $stable(window_shift_o))
      else $error("window moved on plain write");
   AST_SHIFT_ONE: assert property (wr8 && shift_on_write_o && increment_o && window_shift_o < SHIFT_LAST
      |-> ##2 window_shift_o == $past(window_shift_o) + 6'h01) else $error("window step wrong");
   AST_WRAP: assert property (wr8 && increment_o && two_line_o && !glyph_sel_o && address_counter_o == LINE1_LAST
      |-> ##2 address_counter_o == LINE2_BASE) else $error("no wrap to second line");
   AST_HOME: assert property (strobe_i && !register_select_i && eight_bit_o && parallel_data_lines_i == 8'h02
      |-> ##2 address_counter_o == HOME_ADDR && window_shift_o == 6'h00) else $error("home failed");
   AST_SHIFT_KEEPS_COUNT: assert property (strobe_i && !register_select_i && eight_bit_o
      && parallel_data_lines_i[7:3] == 5'h03 |-> ##2 $stable(address_counter_o))
      else $error("display shift moved the counter");
   cover property (wr8 && two_line_o);
   cover property (strobe_i && !eight_bit_o);
   cover property (wr8 && shift_on_write_o);
endmodule // clih_handler_assertions
bind clih_handler clih_handler_assertions i_clih_handler_assertions (.sys_clk_i, .rst_n_i, .strobe_i,
   .register_select_i, .parallel_data_lines_i, .rd_addr_i, .rd_data_o, .address_counter_o, .glyph_sel_o,
   .window_shift_o, .eight_bit_o, .two_line_o, .internal_drive_o, .display_on_o, .cursor_on_o, .blink_on_o,
   .increment_o, .shift_on_write_o, .byte_done_o);
`default_nettype wire

// File: tb/clih_host.sv
// host model: drives write strobe, register select and data lines
`default_nettype none
module clih_host (
   input  wire logic       sys_clk_i,
   output logic            strobe_o,
   output logic            register_select_o,
   output logic [7:0]      parallel_data_lines_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle data lines sit high through the pull-ups; strobe idles low, select starts low and then keeps the last byte's value
   initial begin
      strobe_o = 1'b0;
      register_select_o = 1'b0;
      parallel_data_lines_o = 8'hFF;
   end
   // one byte: a single strobe, or upper then lower nibble back to back
   task automatic put(input logic sel, input logic [7:0] b, input logic four);
      @(posedge sys_clk_i);
      strobe_o <= 1'b1;
      register_select_o <= sel;  // select rides with every byte, in place of a serial control byte
      parallel_data_lines_o <= four ? {b[7:4], 4'hF} : b;
      if (four) begin
         @(posedge sys_clk_i);
         parallel_data_lines_o <= {b[3:0], 4'hF};
      end
      @(posedge sys_clk_i);
      strobe_o <= 1'b0;
      parallel_data_lines_o <= 8'hFF;
      repeat (3) @(posedge sys_clk_i);  // effect lands two edges after the last strobe
   endtask
endmodule // clih_host
`default_nettype wire

// File: tb/tb_clih_handler.sv
// testbench: reset, instruction walk, line wrap and four-bit bring-up
`default_nettype none
module tb_clih_handler
   import clih_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic sel; logic [7:0] d; logic [6:0] cnt; logic [5:0] sh;} clih_row_t;
   // byte sent, then counter and window it should leave
   localparam clih_row_t ROWS [11] = '{'{1'b0, 8'h30, 7'h00, 6'h00}, '{1'b0, 8'h0E, 7'h00, 6'h00},
      '{1'b0, 8'h06, 7'h00, 6'h00}, '{1'b1, 8'h50, 7'h01, 6'h00}, '{1'b1, 8'h48, 7'h02, 6'h00},
      '{1'b0, 8'h07, 7'h02, 6'h00}, '{1'b1, 8'h4D, 7'h03, 6'h01}, '{1'b0, 8'h10, 7'h02, 6'h01},
      '{1'b0, 8'h1C, 7'h02, 6'h00}, '{1'b0, 8'h14, 7'h03, 6'h00}, '{1'b0, 8'h02, 7'h00, 6'h00}};
   logic       sys_clk_i, rst_n_i, strobe_i, register_select_i, glyph_sel_o, eight_bit_o, two_line_o;
   logic       internal_drive_o, display_on_o, cursor_on_o, blink_on_o, increment_o, shift_on_write_o, byte_done_o;
   logic [7:0] parallel_data_lines_i, rd_data_o;
   logic [6:0] rd_addr_i, address_counter_o;
   logic [5:0] window_shift_o;
   int         failures = 0, num_checks = 0;
   int         done_count = 0;
   clih_handler i_clih_handler (.sys_clk_i, .rst_n_i, .strobe_i, .register_select_i, .parallel_data_lines_i,
      .rd_addr_i, .rd_data_o, .address_counter_o, .glyph_sel_o, .window_shift_o, .eight_bit_o, .two_line_o,
      .internal_drive_o, .display_on_o, .cursor_on_o, .blink_on_o, .increment_o, .shift_on_write_o, .byte_done_o);
   clih_host i_clih_host (.sys_clk_i, .strobe_o(strobe_i), .register_select_o(register_select_i),
      .parallel_data_lines_o(parallel_data_lines_i));
   // 8 ns clock
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // count executed bytes mid-cycle, where the one-cycle pulse has settled
   always @(negedge sys_clk_i)
      if (byte_done_o === 1'b1) done_count++;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // text ram read is registered, so look two edges after the address is set
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      rd_addr_i <= a;
      repeat (2) @(posedge sys_clk_i);
      #1 chk(rd_data_o, exp);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      failures++;
      close_out();
   end
   initial begin
      rst_n_i = 1'b0;
      rd_addr_i = 7'h00;
      i_clih_host.put(1'b1, 8'h41, 1'b0);  // a write that spans the reset cycles must be dropped
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      #1 chk({1'b0, address_counter_o}, 8'h00);
      chk({7'h00, eight_bit_o}, 8'h01);
      chk({7'h00, display_on_o}, 8'h00);
      rd(7'h00, BLANK_CODE);
      $display("test reset done");
      foreach (ROWS[i]) begin
         i_clih_host.put(ROWS[i].sel, ROWS[i].d, 1'b0);
         chk({1'b0, address_counter_o}, {1'b0, ROWS[i].cnt});
         chk({2'b0, window_shift_o}, {2'b0, ROWS[i].sh});
      end
      chk({5'h00, display_on_o, cursor_on_o, blink_on_o}, 8'h06);
      chk({5'h00, eight_bit_o, two_line_o, internal_drive_o}, 8'h04);
      chk({6'h00, increment_o, shift_on_write_o}, 8'h03);
      chk(8'(done_count), 8'h0B);
      rd(7'h00, 8'h50);
      rd(7'h02, 8'h4D);
      rd(RAM_LAST, BLANK_CODE);
      $display("test table done");
      i_clih_host.put(1'b0, 8'h38, 1'b0);
      i_clih_host.put(1'b0, 8'h06, 1'b0);
      i_clih_host.put(1'b0, 8'hA7, 1'b0);
      i_clih_host.put(1'b1, 8'h41, 1'b0);
      chk({1'b0, address_counter_o}, {1'b0, LINE2_BASE});
      chk({7'h00, two_line_o}, 8'h01);
      i_clih_host.put(1'b0, 8'h18, 1'b0);
      chk({2'b0, window_shift_o}, 8'h01);
      rd(LINE1_LAST, 8'h41);
      $display("test two-line done");
      // glyph write leaves text alone; clear blanks text; decrement wraps below the first line
      i_clih_host.put(1'b0, 8'h40, 1'b0);
      chk({7'h00, glyph_sel_o}, 8'h01);
      i_clih_host.put(1'b1, 8'h1F, 1'b0);
      chk({1'b0, address_counter_o}, 8'h01);
      rd(7'h00, 8'h50);
      i_clih_host.put(1'b0, 8'h01, 1'b0);
      chk({1'b0, glyph_sel_o, window_shift_o}, 8'h00);
      chk({1'b0, address_counter_o}, {1'b0, HOME_ADDR});
      rd(7'h00, BLANK_CODE);
      i_clih_host.put(1'b0, 8'h04, 1'b0);
      chk({7'h00, increment_o}, 8'h00);
      i_clih_host.put(1'b1, 8'h41, 1'b0);
      chk({1'b0, address_counter_o}, {1'b0, LINE2_LAST});
      rd(7'h00, 8'h41);
      $display("test glyph and clear done");
      rst_n_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      i_clih_host.put(1'b0, 8'h2F, 1'b0);  // lone upper nibble, low lines open
      chk({5'h00, eight_bit_o, two_line_o, internal_drive_o}, 8'h03);
      i_clih_host.put(1'b0, 8'h20, 1'b1);
      chk({5'h00, eight_bit_o, two_line_o, internal_drive_o}, 8'h00);
      i_clih_host.put(1'b1, 8'h50, 1'b1);
      chk({1'b0, address_counter_o}, 8'h01);
      rd(7'h00, 8'h50);
      $display("test four-bit done");
      close_out();
   end
endmodule // tb_clih_handler
`default_nettype wire
